// *** common/abx_pkg.sv ***
/*
 * Package for the add / AND / bit-operation execute block: opcode fields,
 * reset values and the carriers between fetch, file space and execute.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package abx_pkg;
	localparam int DATA_W = 8;
	localparam int INSTR_W = 14;
	localparam int FADDR_W = 7;

	// Opcode field positions
	localparam int OP_HI = 13;
	localparam int OP_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int BITSEL_HI = 9;
	localparam int BITSEL_LO = 7;
	localparam int FADDR_HI = 6;
	localparam int LIT_HI = 7;

	// Opcode patterns
	localparam logic [4:0] OPC_LIT_ADD = 5'h1F;   // 11 111X
	localparam logic [5:0] OPC_FILE_ADD = 6'h07;  // 00 0111
	localparam logic [5:0] OPC_LIT_AND = 6'h39;   // 11 1001
	localparam logic [5:0] OPC_FILE_AND = 6'h05;  // 00 0101
	localparam logic [3:0] OPC_BIT_CLR = 4'h4;    // 01 00bb
	localparam logic [3:0] OPC_BIT_SET = 4'h5;    // 01 01bb
	localparam logic [3:0] OPC_SKIP_LOW = 4'h6;   // 01 10bb
	localparam logic [3:0] OPC_SKIP_HIGH = 4'h7;  // 01 11bb

	// Reset values
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [2:0] FLAGS_RESET = 3'h0;

	typedef struct packed {
		logic valid;
		logic [INSTR_W-1:0] word;
	} abx_instr_t;

	typedef struct packed {
		logic carry;
		logic halfCarry;
		logic zero;
	} abx_flags_t;

	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} abx_fwrite_t;

	typedef enum logic [0:0] {
		ST_RUN = 1'b0,
		ST_SKIP = 1'b1
	} abx_state_t;
endpackage : abx_pkg

// *** logic/abx_execute.sv ***
/*
 * Execute stage for literal/file add, literal/file AND, bit clear/set
 * and bit test with skip. One instruction word per clock.
 * Assumes the file space answers a read of fileAddr combinationally on
 * fileRdData in the same cycle, and applies fileWr at the next edge.
 */
`timescale 1ns/1ps
module abx_execute (
	input wire logic clk,
	input wire logic rst,
	input wire abx_pkg::abx_instr_t instr,
	input wire logic [abx_pkg::DATA_W-1:0] fileRdData,
	output logic [abx_pkg::FADDR_W-1:0] fileAddr,
	output abx_pkg::abx_fwrite_t fileWr,
	output logic [abx_pkg::DATA_W-1:0] wOut,
	output abx_pkg::abx_flags_t flags,
	output logic skipActive
);
	import abx_pkg::*;

	// Architectural state
	logic [DATA_W-1:0] w_reg;
	logic [DATA_W-1:0] w_next;
	abx_flags_t flags_reg;
	abx_flags_t flags_next;
	abx_fwrite_t fwr_reg;
	abx_fwrite_t fwr_next;
	abx_state_t state_reg;
	abx_state_t state_next;

	// Instruction fields
	wire [5:0] opc;
	wire [4:0] opcTop5;
	wire [3:0] opcTop4;
	wire [DATA_W-1:0] lit;
	wire destFile;
	wire [2:0] bitSel;
	wire [FADDR_W-1:0] faddr;
	wire [DATA_W-1:0] bitMask;

	assign opc = instr.word[OP_HI:OP_LO];
	assign opcTop5 = opc[5:1];
	assign opcTop4 = opc[5:2];
	assign lit = instr.word[LIT_HI:0];
	assign destFile = instr.word[DEST_BIT];
	assign bitSel = instr.word[BITSEL_HI:BITSEL_LO];
	assign faddr = instr.word[FADDR_HI:0];
	assign bitMask = 8'h01 << bitSel;

	// A discarded word executes as a NOP
	wire live;
	assign live = instr.valid && (state_reg == ST_RUN);

	// Opcode decode
	wire isLitAdd;
	wire isFileAdd;
	wire isLitAnd;
	wire isFileAnd;
	wire isBitClr;
	wire isBitSet;
	wire isSkipLow;
	wire isSkipHigh;

	assign isLitAdd = live && (opcTop5 == OPC_LIT_ADD);
	assign isFileAdd = live && (opc == OPC_FILE_ADD);
	assign isLitAnd = live && (opc == OPC_LIT_AND);
	assign isFileAnd = live && (opc == OPC_FILE_AND);
	assign isBitClr = live && (opcTop4 == OPC_BIT_CLR);
	assign isBitSet = live && (opcTop4 == OPC_BIT_SET);
	assign isSkipLow = live && (opcTop4 == OPC_SKIP_LOW);
	assign isSkipHigh = live && (opcTop4 == OPC_SKIP_HIGH);

	// Instruction classes
	wire isAdd;
	wire isAnd;
	wire isLitOp;
	wire isFileAlu;
	wire isBitOp;

	assign isAdd = isLitAdd || isFileAdd;
	assign isAnd = isLitAnd || isFileAnd;
	assign isLitOp = isLitAdd || isLitAnd;
	assign isFileAlu = isFileAdd || isFileAnd;
	assign isBitOp = isBitClr || isBitSet;

	// Second operand: literal or file register
	wire [DATA_W-1:0] operand;
	assign operand = isLitOp ? lit : fileRdData;

	// Adder with carry out of bit 3 and bit 7
	wire [4:0] lowSum;
	wire [DATA_W:0] fullSum;
	wire [DATA_W-1:0] sumRes;
	wire [DATA_W-1:0] andRes;
	wire [DATA_W-1:0] aluRes;

	assign lowSum = {1'b0, w_reg[3:0]} + {1'b0, operand[3:0]};
	assign fullSum = {1'b0, w_reg} + {1'b0, operand};
	assign sumRes = fullSum[DATA_W-1:0];
	assign andRes = w_reg & operand;
	assign aluRes = isAdd ? sumRes : andRes;

	// Bit operations on the addressed file register
	wire [DATA_W-1:0] clrRes;
	wire [DATA_W-1:0] setRes;
	wire [DATA_W-1:0] bitRes;
	wire bitVal;

	assign clrRes = fileRdData & ~bitMask;
	assign setRes = fileRdData | bitMask;
	assign bitRes = isBitSet ? setRes : clrRes;
	assign bitVal = |(fileRdData & bitMask);

	// Skip decision
	wire takeSkip;
	assign takeSkip = (isSkipLow && !bitVal) || (isSkipHigh && bitVal);

	// Destination selection
	wire toW;
	wire toFile;

	assign toW = isLitOp || (isFileAlu && !destFile);
	assign toFile = isFileAlu && destFile;

	// Working register next value
	assign w_next = toW ? aluRes : w_reg;

	// Flags; AND and bit ops leave carry and half carry alone
	wire carryNext;
	wire halfNext;
	wire zeroNext;
	wire zeroNew;

	assign zeroNew = (aluRes == 8'h00);
	assign carryNext = isAdd ? fullSum[DATA_W] : flags_reg.carry;
	assign halfNext = isAdd ? lowSum[4] : flags_reg.halfCarry;
	assign zeroNext = (isAdd || isAnd) ? zeroNew : flags_reg.zero;
	assign flags_next = '{carry: carryNext, halfCarry: halfNext, zero: zeroNext};

	// File write, applied by the file space one edge later
	wire fileWe;
	wire [DATA_W-1:0] fileData;

	assign fileWe = toFile || isBitOp;
	assign fileData = toFile ? aluRes : bitRes;
	assign fwr_next = '{we: fileWe, addr: faddr, data: fileData};

	// Skip state: wait for the next valid word and drop it
	always_comb begin
		unique case (state_reg)
			ST_RUN: state_next = takeSkip ? ST_SKIP : ST_RUN;
			ST_SKIP: state_next = instr.valid ? ST_RUN : ST_SKIP;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_reg <= W_RESET;
		end else begin
			w_reg <= w_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fwr_reg <= '0;
		end else begin
			fwr_reg <= fwr_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Only output not from a flop: file read must happen this cycle
	assign fileAddr = faddr;
	assign fileWr = fwr_reg;
	assign wOut = w_reg;
	assign flags = flags_reg;
	assign skipActive = (state_reg == ST_SKIP);
endmodule : abx_execute

// *** verif/abx_monitor.sv ***
/* Execute-stage checker. Sees only abx_execute ports; bound below. */
`timescale 1ns/1ps
module abx_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire abx_pkg::abx_instr_t instr,
	input wire logic [7:0] fileRdData,
	input wire logic [6:0] fileAddr,
	input wire abx_pkg::abx_fwrite_t fileWr,
	input wire logic [7:0] wOut,
	input wire abx_pkg::abx_flags_t flags,
	input wire logic skipActive
);
	wire t = instr.valid && !skipActive;
	wire [7:0] k = instr.word[7:0], m = 8'h01 << instr.word[9:7];
	wire [5:0] o = instr.word[13:8];
	wire h = |(fileRdData & m);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_lit_add: assert property (t&&o[5:1]==5'h1F |=> wOut==$past(wOut)+$past(k)) else $error("ladd");
	chk_file_add: assert property (t&&o==6'h07&&k[7] |=> fileWr.data==$past(wOut)+$past(fileRdData))
		else $error("fadd");
	chk_lit_and: assert property (t&&o==6'h39 |=> wOut==($past(wOut)&$past(k))) else $error("land");
	chk_file_and: assert property (t&&o==6'h05&&!k[7] |=> wOut==($past(wOut)&$past(fileRdData)))
		else $error("fand");
	chk_bit_clr: assert property (t&&o[5:2]==4'h4 |=> fileWr.data==($past(fileRdData)&~$past(m))) else $error("bclr");
	chk_bit_set: assert property (t&&o[5:2]==4'h5 |=> fileWr.data==($past(fileRdData)|$past(m))) else $error("bset");
	chk_skip_low: assert property (t&&o[5:2]==4'h6 |=> skipActive==!$past(h)) else $error("skl");
	chk_skip_high: assert property (t&&o[5:2]==4'h7 |=> skipActive==$past(h)) else $error("skh");
endmodule : abx_monitor
bind abx_execute abx_monitor mon (.clk, .rst, .instr, .fileRdData, .fileAddr, .fileWr, .wOut, .flags, .skipActive);

// *** verif/abx_file_model.sv ***
/* File space: read of fileAddr at once, write at the edge. */
`timescale 1ns/1ps
module abx_file_model (
	input wire logic clk,
	input wire logic [6:0] fileAddr,
	input wire abx_pkg::abx_fwrite_t fileWr,
	output logic [7:0] fileRdData
);
	logic [7:0] mem [128];
	assign fileRdData = mem[fileAddr];
	always @(posedge clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
endmodule : abx_file_model

// *** verif/add_and_bit_op_execute_tb_top.sv ***
/* Bench: abx_execute against abx_file_model. */
`timescale 1ns/1ps
module add_and_bit_op_execute_tb_top;
	import abx_pkg::*;
	logic clk = 0, rst = 1, skipActive;
	logic [7:0] fileRdData, wOut;
	logic [6:0] fileAddr;
	abx_instr_t instr = '0;
	abx_fwrite_t fileWr;
	abx_flags_t flags;
	int n_mismatch = 0, n_tests = 0;
	always #5 clk = ~clk;
	abx_execute dut (.clk, .rst, .instr, .fileRdData, .fileAddr, .fileWr, .wOut, .flags, .skipActive);
	abx_file_model fm (.clk, .fileAddr, .fileWr, .fileRdData);
	task chk(input logic [10:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %h %h", $time, g, e);
		end
	endtask : chk
	task run(input logic [13:0] w);
		@(negedge clk) instr = {1'b1, w};
		@(negedge clk) instr = '0;
		@(negedge clk);
	endtask : run
	task tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task s_arith;
		fm.mem[7'h21] = 8'h05;
		fm.mem[7'h22] = 8'h88;
		run(14'h3EF0);
		run(14'h07A1);
		run(14'h0722);
		chk({wOut, flags}, {8'h78, 3'h4});
		run(14'h393C);
		chk({wOut, flags}, {8'h38, 3'h4});
		run(14'h05A2);
		run(14'h0522);
		chk({wOut, flags}, {8'h08, 3'h4});
		run(14'h3FF8);
		chk({wOut, flags}, {8'h00, 3'h7});
		chk({fm.mem[7'h21], flags}, {8'hF5, 3'h7});
		chk({fm.mem[7'h22], flags}, {8'h08, 3'h7});
	endtask : s_arith
	task s_bits;
		fm.mem[7'h30] = 8'hFF;
		fm.mem[7'h31] = 8'h00;
		for (int b = 0; b < 8; b++) begin
			run({4'h4, b[2:0], 7'h30});
			run({4'h5, b[2:0], 7'h31});
			chk({fm.mem[7'h30], flags}, {8'(8'hFF << (b + 1)), 3'h7});
			chk({fm.mem[7'h31], flags}, {8'((2 << b) - 1), 3'h7});
		end
	endtask : s_bits
	task s_skip(input logic [13:0] w, input logic [7:0] e);
		run(w);
		run(14'h3E01);
		chk({wOut, flags}, {e, 3'h0});
	endtask : s_skip
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		s_arith;
		s_bits;
		fm.mem[7'h40] = 8'h08;
		s_skip({4'h6, 3'h3, 7'h40}, 8'h01);
		s_skip({4'h6, 3'h2, 7'h40}, 8'h01);
		s_skip({4'h7, 3'h3, 7'h40}, 8'h01);
		s_skip({4'h7, 3'h2, 7'h40}, 8'h02);
		tally_and_finish;
	end
endmodule : add_and_bit_op_execute_tb_top
